// ### inc/ctp_defines.svh
// Constants of the core timing and power control block.
// Assumes inclusion by bare name from any design file.
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH

// =====================================================
// Power control register
`define CTP_PWR_CTL_ADDR  8'h87
`define CTP_PWR_CTL_RESET 8'h00
`define CTP_FLAGS_RESET   6'h00
`define CTP_FLAGS_MSB     7
`define CTP_FLAGS_LSB     2
`define CTP_STOP_BIT   1
`define CTP_IDLE_BIT   0

// =====================================================
// Timing
`define CTP_MAX_CYCLES 4'h8
`define CTP_CNT_IDLE   4'h0
`define CTP_CNT_LAST   4'h1

`endif

// ### inc/ctp_pkg.sv
// Types shared by the core timing and power control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ctp_pkg;

  // =====================================================
  // Power modes
  typedef enum logic [1:0] {
    CTP_RUN  = 2'b00,
    CTP_IDLE = 2'b01,
    CTP_STOP = 2'b10
  } ctp_pmode_e;

  // =====================================================
  // Operand addressing kinds
  typedef enum logic [2:0] {
    CTP_AM_NONE = 3'b000,
    CTP_AM_REG  = 3'b001,
    CTP_AM_DIR  = 3'b010,
    CTP_AM_IND  = 3'b011,
    CTP_AM_IMM  = 3'b100
  } ctp_amode_e;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic       cond;
    ctp_amode_e amode;
  } ctp_timing_s;

  typedef struct packed {
    ctp_pmode_e mode;
    logic [5:0] flags;
    logic       stop_pend;
    logic       idle_pend;
    logic [7:0] rdata;
    logic       wake;
    logic       restart;
  } ctp_pwr_state_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic [3:0] cycles;
    logic [1:0] bytes;
    ctp_amode_e amode;
  } ctp_seq_state_s;

endpackage : ctp_pkg

// ### inc/ctp_if.sv
// Carrier between the top module, the sequencer and the power control.
// Assumes the top module drives the opcode, branch, SFR and interrupt signals.
`timescale 1ns/1ns
`default_nettype none
interface ctp_if;
  import ctp_pkg::*;
  logic        sfr_we;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        irq;
  logic        instr_end;
  logic        busy;
  logic        halt_req;
  logic        cpu_run;
  ctp_pmode_e  mode;
  logic        wake;
  logic        restart;
  logic        op_valid;
  logic        br_taken;
  ctp_timing_s timing;
  logic        ready;
  logic [3:0]  cycles;
  logic [1:0]  bytes;
  ctp_amode_e  amode;

  modport pwr (input sfr_we, sfr_rd, sfr_addr, sfr_wdata, irq, instr_end, busy,
               output sfr_rdata, halt_req, cpu_run, mode, wake, restart);
  modport seq (input op_valid, br_taken, timing, cpu_run, halt_req,
               output ready, instr_end, busy, cycles, bytes, amode);
endinterface : ctp_if
`default_nettype wire

// ### hdl/ctp_power.sv
// Power control register and run/idle/stop mode state.
// Assumes SFR strobes are one-cycle and synchronous to i_clk.
`include "ctp_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ctp_power (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  ctp_if.pwr        bus
);
  import ctp_pkg::*;

  ctp_pwr_state_s state_reg;
  ctp_pwr_state_s state_next;
  logic           hit;
  logic           want_stop;
  logic           want_idle;
  logic           at_boundary;

  // =====================================================
  // Decode, page independent
  assign hit         = (bus.sfr_addr == `CTP_PWR_CTL_ADDR); // RULE1
  assign want_stop   = state_reg.stop_pend | (hit & bus.sfr_we & bus.sfr_wdata[`CTP_STOP_BIT]);
  assign want_idle   = state_reg.idle_pend | (hit & bus.sfr_we & bus.sfr_wdata[`CTP_IDLE_BIT]);
  // Halt only once the writing instruction has retired
  assign at_boundary = bus.instr_end | ~bus.busy; // RULE17
  assign bus.halt_req  = (state_reg.mode == CTP_RUN) & (want_stop | want_idle) & at_boundary;
  assign bus.cpu_run   = (state_reg.mode == CTP_RUN);
  assign bus.mode      = state_reg.mode;
  assign bus.sfr_rdata = state_reg.rdata;
  assign bus.wake      = state_reg.wake;
  assign bus.restart   = state_reg.restart;

  // =====================================================
  // Next state
  always_comb begin
    state_next         = state_reg;
    state_next.wake    = 1'b0;
    state_next.restart = 1'b0;
    if (hit & bus.sfr_rd) begin
      state_next.rdata = {state_reg.flags, 2'b00}; // RULE4
    end else if (bus.sfr_rd) begin
      state_next.rdata = 8'h00;
    end
    if (hit & bus.sfr_we) begin
      state_next.flags = bus.sfr_wdata[`CTP_FLAGS_MSB:`CTP_FLAGS_LSB]; // RULE2
    end
    case (state_reg.mode)
      CTP_RUN: begin
        state_next.stop_pend = want_stop;
        state_next.idle_pend = want_idle;
        if (want_stop & at_boundary) begin
          state_next.mode      = CTP_STOP; // RULE3
          state_next.stop_pend = 1'b0;
          state_next.idle_pend = 1'b0;
        end else if (want_idle & at_boundary) begin
          state_next.mode      = CTP_IDLE; // RULE5
          state_next.idle_pend = 1'b0;
        end
      end
      CTP_IDLE: begin
        if (bus.irq) begin
          state_next.mode = CTP_RUN; // RULE18
          state_next.wake = 1'b1;
        end
      end
      // No exit but reset
      CTP_STOP: state_next.mode = CTP_STOP; // RULE19
      default:  state_next.mode = CTP_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= '{CTP_RUN, `CTP_FLAGS_RESET, 1'b0, 1'b0, `CTP_PWR_CTL_RESET, 1'b0, 1'b1}; // RULE19
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ctp_power
`default_nettype wire

// ### hdl/ctp_seq.sv
// Instruction execution sequencer counting system clock cycles.
// Assumes the decoded timing is valid while op_valid is high.
`include "ctp_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ctp_seq (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  ctp_if.seq        bus
);
  import ctp_pkg::*;

  ctp_seq_state_s state_reg;
  ctp_seq_state_s state_next;
  logic [3:0]     run_len;
  logic           take;

  // =====================================================
  // Handshake; last cycle overlaps next accept for 1/clock
  assign take       = bus.ready & bus.op_valid;
  assign run_len    = (bus.timing.cond & ~bus.br_taken) ? bus.timing.cycles - 4'h1 : bus.timing.cycles; // RULE9
  assign bus.ready  = bus.cpu_run & ~bus.halt_req & (state_reg.cnt <= `CTP_CNT_LAST); // RULE11
  assign bus.instr_end = (state_reg.cnt == `CTP_CNT_LAST);
  assign bus.busy   = (state_reg.cnt != `CTP_CNT_IDLE);
  assign bus.cycles = state_reg.cycles;
  assign bus.bytes  = state_reg.bytes;
  assign bus.amode  = state_reg.amode;

  // =====================================================
  // Plain clock counting, no machine cycles
  always_comb begin
    state_next = state_reg;
    if (take) begin
      state_next.cnt    = run_len; // RULE7
      state_next.cycles = run_len;
      state_next.bytes  = bus.timing.bytes;
      state_next.amode  = bus.timing.amode;
    end else if (state_reg.cnt != `CTP_CNT_IDLE) begin
      state_next.cnt = state_reg.cnt - 4'h1; // RULE7
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= '{`CTP_CNT_IDLE, `CTP_CNT_IDLE, 2'h0, CTP_AM_NONE};
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ctp_seq
`default_nettype wire

// ### hdl/ctp_core_timing.sv
// Top of the core timing and power control block: opcode timing decode,
// execution sequencer and power control register.
// Assumes a fetch unit presents one opcode at a time and an SFR bus
// whose strobes are one-cycle pulses synchronous to I_MCLK.
//
// Contract
// (RULE1) Power control register sits at SFR 0x87 on every page.
// (RULE2) Bits 7:2 are six software flags, read back as written.
// (RULE3) Writing bit 1 enters stop: CPU and internal oscillator halt.
// (RULE4) Stop and idle select bits always read zero.
// (RULE5) Writing bit 0 gates the CPU clock only; peripherals keep clocks.
// (RULE6) Opcode encoding and addressing match the standard 8-bit architecture.
// (RULE7) Execution counts plain system clocks, no machine cycles.
// (RULE8) Most instructions take as many clocks as bytes.
// (RULE9) Untaken conditional branch takes one clock fewer than taken.
// (RULE10) No instruction exceeds eight clocks; divide takes exactly eight.
// (RULE11) Works at any clock rate, one instruction per clock at best.
// (RULE12) Accumulator op with bank register operand: one byte, one clock.
// (RULE13) Accumulator op with direct operand: two bytes, two clocks.
// (RULE14) Pointer-indirect operand ops: one byte, two clocks; the code gives E2, E3, F2, F3 three clocks and 76-77, 86-87, A6-A7 two bytes.
// (RULE15) Accumulator op with immediate operand: two bytes, two clocks.
// (RULE16) Logical immediate into direct byte: three bytes, three clocks.
// (RULE17) Idle or stop begins only after the setting instruction ends.
// (RULE18) Enabled interrupt in idle clears idle and resumes the CPU.
// (RULE19) Stop ends only by reset, then restart from address zero.
`include "ctp_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ctp_core_timing (
  input  wire logic       I_MCLK,
  input  wire logic       I_RSTN,
  input  wire logic [7:0] I_OPCODE,
  input  wire logic       I_OP_VALID,
  input  wire logic       I_BR_TAKEN,
  output logic            O_OP_READY,
  output logic            O_INSTR_DONE,
  output logic [3:0]      O_EXEC_CYCLES,
  output logic [1:0]      O_EXEC_BYTES,
  output logic [2:0]      O_OPERAND_MODE,
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_SFR_WE,
  input  wire logic       I_SFR_RD,
  input  wire logic [7:0] I_SFR_WDATA,
  output logic [7:0]      O_SFR_RDATA,
  input  wire logic       I_IRQ_PEND,
  output logic            O_CPU_CLK_EN,
  output logic            O_PERIPH_CLK_EN,
  output logic            O_OSC_EN,
  output logic            O_IDLE,
  output logic            O_STOP,
  output logic            O_WAKE,
  output logic            O_RESTART
);
  import ctp_pkg::*;

  ctp_if link ();

  // =====================================================
  // Opcode timing table
  // Conditional entries hold the taken count.
  function automatic ctp_timing_s op_timing(input logic [7:0] op);
    ctp_timing_s t;
    t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE}; // RULE8
    casez (op) // RULE6
      // Column 0: branches and misc
      8'h00: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h10: t = '{2'h3, 4'h5, 1'b1, CTP_AM_DIR}; // RULE9
      8'h20: t = '{2'h3, 4'h5, 1'b1, CTP_AM_DIR}; // RULE9
      8'h30: t = '{2'h3, 4'h5, 1'b1, CTP_AM_DIR}; // RULE9
      8'h40: t = '{2'h2, 4'h4, 1'b1, CTP_AM_NONE}; // RULE9
      8'h50: t = '{2'h2, 4'h4, 1'b1, CTP_AM_NONE}; // RULE9
      8'h60: t = '{2'h2, 4'h4, 1'b1, CTP_AM_NONE}; // RULE9
      8'h70: t = '{2'h2, 4'h4, 1'b1, CTP_AM_NONE}; // RULE9
      8'h80: t = '{2'h2, 4'h4, 1'b0, CTP_AM_NONE};
      8'h90: t = '{2'h3, 4'h3, 1'b0, CTP_AM_IMM};
      8'hA0: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hB0: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hC0: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hD0: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hE0: t = '{2'h1, 4'h3, 1'b0, CTP_AM_NONE};
      8'hF0: t = '{2'h1, 4'h3, 1'b0, CTP_AM_NONE};
      // Column 1: absolute jump and call
      8'b???0_0001: t = '{2'h2, 4'h4, 1'b0, CTP_AM_NONE};
      8'b???1_0001: t = '{2'h2, 4'h4, 1'b0, CTP_AM_NONE};
      // Column 2
      8'h02: t = '{2'h3, 4'h5, 1'b0, CTP_AM_NONE};
      8'h12: t = '{2'h3, 4'h5, 1'b0, CTP_AM_NONE};
      8'h22: t = '{2'h1, 4'h6, 1'b0, CTP_AM_NONE};
      8'h32: t = '{2'h1, 4'h6, 1'b0, CTP_AM_NONE};
      8'h42: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h52: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h62: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h72: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h82: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h92: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hA2: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hB2: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hC2: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hD2: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hE2: t = '{2'h1, 4'h3, 1'b0, CTP_AM_IND};
      8'hF2: t = '{2'h1, 4'h3, 1'b0, CTP_AM_IND};
      // Column 3
      8'h03: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h13: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h23: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h33: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h43: t = '{2'h3, 4'h3, 1'b0, CTP_AM_DIR}; // RULE16
      8'h53: t = '{2'h3, 4'h3, 1'b0, CTP_AM_DIR}; // RULE16
      8'h63: t = '{2'h3, 4'h3, 1'b0, CTP_AM_DIR}; // RULE16
      8'h73: t = '{2'h1, 4'h4, 1'b0, CTP_AM_NONE};
      8'h83: t = '{2'h1, 4'h3, 1'b0, CTP_AM_NONE};
      8'h93: t = '{2'h1, 4'h3, 1'b0, CTP_AM_NONE};
      8'hA3: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hB3: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hC3: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hD3: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hE3: t = '{2'h1, 4'h3, 1'b0, CTP_AM_IND};
      8'hF3: t = '{2'h1, 4'h3, 1'b0, CTP_AM_IND};
      // Column 4: accumulator and immediate
      8'h04: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h14: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'h24: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'h34: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'h44: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'h54: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'h64: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'h74: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM};
      8'h84: t = '{2'h1, `CTP_MAX_CYCLES, 1'b0, CTP_AM_NONE}; // RULE10
      8'h94: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IMM}; // RULE15
      8'hA4: t = '{2'h1, 4'h4, 1'b0, CTP_AM_NONE};
      8'hB4: t = '{2'h3, 4'h5, 1'b1, CTP_AM_IMM}; // RULE9
      8'hC4: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hD4: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hE4: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hF4: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      // Column 5: direct byte
      8'h05: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h15: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'h25: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'h35: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'h45: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'h55: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'h65: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'h75: t = '{2'h3, 4'h3, 1'b0, CTP_AM_IMM};
      8'h85: t = '{2'h3, 4'h3, 1'b0, CTP_AM_DIR};
      8'h95: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR}; // RULE13
      8'hA5: t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
      8'hB5: t = '{2'h3, 4'h6, 1'b1, CTP_AM_DIR}; // RULE9
      8'hC5: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hD5: t = '{2'h3, 4'h5, 1'b1, CTP_AM_DIR}; // RULE9
      8'hE5: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      8'hF5: t = '{2'h2, 4'h2, 1'b0, CTP_AM_DIR};
      // Columns 6-7: pointer indirect
      8'b0000_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0001_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0010_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0011_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0100_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0101_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0110_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b0111_011?: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IND};
      8'b1000_011?: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IND};
      8'b1001_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b1010_011?: t = '{2'h2, 4'h2, 1'b0, CTP_AM_IND};
      8'b1011_011?: t = '{2'h3, 4'h6, 1'b1, CTP_AM_IND}; // RULE9
      8'b1100_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b1101_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b1110_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      8'b1111_011?: t = '{2'h1, 4'h2, 1'b0, CTP_AM_IND}; // RULE14
      // Columns 8-F: bank register
      8'b0000_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG};
      8'b0001_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG};
      8'b0010_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b0011_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b0100_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b0101_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b0110_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b0111_1???: t = '{2'h2, 4'h2, 1'b0, CTP_AM_REG};
      8'b1000_1???: t = '{2'h2, 4'h2, 1'b0, CTP_AM_REG};
      8'b1001_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG}; // RULE12
      8'b1010_1???: t = '{2'h2, 4'h2, 1'b0, CTP_AM_REG};
      8'b1011_1???: t = '{2'h3, 4'h5, 1'b1, CTP_AM_REG}; // RULE9
      8'b1100_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG};
      8'b1101_1???: t = '{2'h2, 4'h4, 1'b1, CTP_AM_REG}; // RULE9
      8'b1110_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG};
      8'b1111_1???: t = '{2'h1, 4'h1, 1'b0, CTP_AM_REG};
      default:      t = '{2'h1, 4'h1, 1'b0, CTP_AM_NONE};
    endcase
    return t;
  endfunction : op_timing

  // =====================================================
  // Carrier wiring
  assign link.timing    = op_timing(I_OPCODE);
  assign link.op_valid  = I_OP_VALID;
  assign link.br_taken  = I_BR_TAKEN;
  assign link.sfr_we    = I_SFR_WE;
  assign link.sfr_rd    = I_SFR_RD;
  assign link.sfr_addr  = I_SFR_ADDR;
  assign link.sfr_wdata = I_SFR_WDATA;
  assign link.irq       = I_IRQ_PEND;

  // =====================================================
  // Sequencer and power control
  ctp_seq u_seq (
    .i_clk  (I_MCLK),
    .i_rstn (I_RSTN),
    .bus    (link)
  );

  ctp_power u_power (
    .i_clk  (I_MCLK),
    .i_rstn (I_RSTN),
    .bus    (link)
  );

  // =====================================================
  // Outputs
  assign O_OP_READY     = link.ready;
  assign O_INSTR_DONE   = link.instr_end;
  assign O_EXEC_CYCLES  = link.cycles;
  assign O_EXEC_BYTES   = link.bytes;
  assign O_OPERAND_MODE = link.amode;
  assign O_SFR_RDATA    = link.sfr_rdata;
  assign O_WAKE         = link.wake;
  assign O_RESTART      = link.restart;

  // Enables, not gated clocks: the clock tree gates on these
  assign O_CPU_CLK_EN    = (link.mode == CTP_RUN); // RULE5
  assign O_PERIPH_CLK_EN = (link.mode != CTP_STOP); // RULE5
  assign O_OSC_EN        = (link.mode != CTP_STOP); // RULE3
  assign O_IDLE          = (link.mode == CTP_IDLE);
  assign O_STOP          = (link.mode == CTP_STOP);
endmodule : ctp_core_timing
`default_nettype wire

// ### verif/ctp_core_timing_asserts.sv
// Checker of the core timing and power control top module.
// Assumes it is bound to ctp_core_timing and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module ctp_core_timing_asserts (
  input wire logic       I_MCLK,
  input wire logic       I_RSTN,
  input wire logic [7:0] I_OPCODE,
  input wire logic       I_OP_VALID,
  input wire logic       O_OP_READY,
  input wire logic       O_INSTR_DONE,
  input wire logic [3:0] O_EXEC_CYCLES,
  input wire logic [1:0] O_EXEC_BYTES,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic       I_SFR_WE,
  input wire logic       I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic       I_IRQ_PEND,
  input wire logic       O_CPU_CLK_EN,
  input wire logic       O_PERIPH_CLK_EN,
  input wire logic       O_OSC_EN,
  input wire logic       O_IDLE,
  input wire logic       O_STOP,
  input wire logic       O_WAKE,
  input wire logic       O_RESTART
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  // =====================================================
  // Helper: an instruction is in flight until its last cycle
  logic take;
  logic inflight_reg;
  assign take = I_OP_VALID && O_OP_READY;
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) inflight_reg <= 1'b0;
    else if (take) inflight_reg <= 1'b1;
    else if (O_INSTR_DONE) inflight_reg <= 1'b0;
  end
  // =====================================================
  // Properties
  a_done_in_eight: assert property (take |-> ##[1:8] O_INSTR_DONE) else $error("instruction not done");
  a_cycles_cap: assert property (O_EXEC_CYCLES <= 4'h8) else $error("cycle count above eight");
  a_div_eight: assert property (take && I_OPCODE == 8'h84 |=> !O_INSTR_DONE [*7] ##1 O_INSTR_DONE)
    else $error("divide timing");
  a_bank_one: assert property (take && I_OPCODE[7:3] == 5'h05 |=> O_INSTR_DONE && O_EXEC_BYTES == 2'h1)
    else $error("bank op timing");
  a_direct_two: assert property (take && I_OPCODE == 8'h25 |=> O_EXEC_CYCLES == 4'h2 && !O_INSTR_DONE ##1 O_INSTR_DONE)
    else $error("direct op timing");
  a_sel_read_zero: assert property (O_SFR_RDATA[1:0] == 2'h0) else $error("select bits read");
  a_flag_readback: assert property (I_SFR_WE && I_SFR_ADDR == 8'h87 ##1 !I_SFR_WE ##1 I_SFR_RD && !I_SFR_WE
    && I_SFR_ADDR == 8'h87 |=> O_SFR_RDATA[7:2] == $past(I_SFR_WDATA[7:2], 3)) else $error("flags lost");
  a_idle_clocks: assert property (O_IDLE |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN && O_OSC_EN && !O_OP_READY)
    else $error("idle clocks");
  a_stop_clocks: assert property (O_STOP |-> !O_CPU_CLK_EN && !O_OSC_EN && !O_OP_READY)
    else $error("stop clocks");
  a_stop_holds: assert property (O_STOP |=> O_STOP && !O_WAKE) else $error("stop left");
  a_idle_wake: assert property (O_IDLE && I_IRQ_PEND |=> !O_IDLE && O_WAKE && O_CPU_CLK_EN)
    else $error("idle not left");
  a_halt_after_end: assert property (inflight_reg && !O_INSTR_DONE |=> !O_IDLE && !O_STOP)
    else $error("halt mid instruction");
  a_restart_pulse: assert property ($rose(I_RSTN) |-> O_RESTART ##1 !O_RESTART) else $error("restart");
endmodule : ctp_core_timing_asserts
bind ctp_core_timing ctp_core_timing_asserts i_chk (.I_MCLK, .I_RSTN, .I_OPCODE, .I_OP_VALID, .O_OP_READY,
  .O_INSTR_DONE, .O_EXEC_CYCLES, .O_EXEC_BYTES, .I_SFR_ADDR, .I_SFR_WE, .I_SFR_RD, .I_SFR_WDATA, .O_SFR_RDATA,
  .I_IRQ_PEND, .O_CPU_CLK_EN, .O_PERIPH_CLK_EN, .O_OSC_EN, .O_IDLE, .O_STOP, .O_WAKE, .O_RESTART);
`default_nettype wire

// ### verif/tb_ctp_core_timing.sv
// Self-checking bench of the core timing and power control block.
// Assumes the checker file is compiled alongside for its bind.
`timescale 1ns/1ns
`default_nettype none
module tb_ctp_core_timing;
  logic       mclk, rstn, op_valid, br_taken, sfr_we, sfr_rd, irq_pend;
  logic [7:0] opcode, sfr_addr, sfr_wdata, sfr_rdata;
  logic       op_ready, instr_done, cpu_clk_en, periph_clk_en, osc_en, idle, stop, wake, restart;
  logic [3:0] exec_cycles;
  logic [1:0] exec_bytes;
  logic [2:0] operand_mode;
  int         err_count, total_checks;
  // Opcode, taken, cycles, bytes, mode; mode 7 means not checked
  localparam logic [17:0] TBL [11] = '{{8'h28,1'b0,4'h1,2'h1,3'h1}, {8'h25,1'b0,4'h2,2'h2,3'h2},
    {8'h26,1'b0,4'h2,2'h1,3'h3}, {8'h24,1'b0,4'h2,2'h2,3'h4}, {8'h53,1'b0,4'h3,2'h3,3'h7},
    {8'h43,1'b0,4'h3,2'h3,3'h7}, {8'h84,1'b0,4'h8,2'h1,3'h7}, {8'hA4,1'b0,4'h4,2'h1,3'h7},
    {8'h40,1'b1,4'h4,2'h2,3'h7}, {8'h40,1'b0,4'h3,2'h2,3'h7}, {8'hE8,1'b0,4'h1,2'h1,3'h1}};
  ctp_core_timing i_dut (.I_MCLK(mclk), .I_RSTN(rstn), .I_OPCODE(opcode), .I_OP_VALID(op_valid),
    .I_BR_TAKEN(br_taken), .O_OP_READY(op_ready), .O_INSTR_DONE(instr_done), .O_EXEC_CYCLES(exec_cycles),
    .O_EXEC_BYTES(exec_bytes), .O_OPERAND_MODE(operand_mode), .I_SFR_ADDR(sfr_addr), .I_SFR_WE(sfr_we),
    .I_SFR_RD(sfr_rd), .I_SFR_WDATA(sfr_wdata), .O_SFR_RDATA(sfr_rdata), .I_IRQ_PEND(irq_pend),
    .O_CPU_CLK_EN(cpu_clk_en), .O_PERIPH_CLK_EN(periph_clk_en), .O_OSC_EN(osc_en), .O_IDLE(idle),
    .O_STOP(stop), .O_WAKE(wake), .O_RESTART(restart));
  // =====================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic do_reset;
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (14) @(posedge mclk);
    @(negedge mclk);
    chk("restart", 8'h01, {7'h0, restart});
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
  endtask : do_reset
  // One strobe cycle on the register port; read data sampled after it
  task automatic sfr(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_we <= we;
    sfr_rd <= !we;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_we <= 1'b0;
    sfr_rd <= 1'b0;
    @(negedge mclk);
  endtask : sfr
  task automatic irq;
    @(posedge mclk);
    irq_pend <= 1'b1;
    @(posedge mclk);
    irq_pend <= 1'b0;
    @(negedge mclk);
  endtask : irq
  task automatic exec(input logic [17:0] t);
    int n;
    @(posedge mclk);
    opcode <= t[17:10];
    br_taken <= t[9];
    op_valid <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b0;
    for (n = 1; n < 12; n++) begin
      @(negedge mclk);
      if (n == 1) begin
        chk("bytes", {6'h0, t[4:3]}, {6'h0, exec_bytes});
        chk("exec cycles", {4'h0, t[8:5]}, {4'h0, exec_cycles});
        if (t[2:0] != 3'h7) chk("mode", {5'h0, t[2:0]}, {5'h0, operand_mode});
      end
      if (instr_done === 1'b1) break;
    end
    chk("cycles", {4'h0, t[8:5]}, n[7:0]);
  endtask : exec
  // =====================================================
  // Scenarios
  task automatic t_timing;
    foreach (TBL[i]) exec(TBL[i]);
    $display("test timing done");
  endtask : t_timing
  task automatic t_regs;
    sfr(1'b0, 8'h87, 8'h00);
    chk("reset value", 8'h00, sfr_rdata);
    sfr(1'b1, 8'h87, 8'hA8);
    sfr(1'b0, 8'h87, 8'h00);
    chk("flags", 8'hA8, sfr_rdata);
    sfr(1'b1, 8'h86, 8'h54);
    sfr(1'b0, 8'h86, 8'h00);
    chk("other addr", 8'h00, sfr_rdata);
    sfr(1'b0, 8'h87, 8'h00);
    chk("flags kept", 8'hA8, sfr_rdata);
    $display("test regs done");
  endtask : t_regs
  task automatic t_idle;
    sfr(1'b1, 8'h87, 8'hA9);
    @(negedge mclk);
    chk("idle clocks", 8'h0B, {4'h0, idle, cpu_clk_en, periph_clk_en, osc_en});
    chk("ready", 8'h00, {7'h0, op_ready});
    sfr(1'b0, 8'h87, 8'h00);
    chk("idle read", 8'hA8, sfr_rdata);
    irq();
    chk("wake", 8'h03, {5'h0, idle, wake, cpu_clk_en});
    $display("test idle done");
  endtask : t_idle
  // Back to back ops, then an idle request made while a divide runs
  task automatic t_pipe;
    @(posedge mclk);
    opcode <= 8'h28;
    op_valid <= 1'b1;
    repeat (2) @(posedge mclk);
    opcode <= 8'h84;
    @(negedge mclk);
    chk("one per clock", 8'h03, {6'h0, instr_done, op_ready});
    @(posedge mclk);
    op_valid <= 1'b0;
    {sfr_we, sfr_addr, sfr_wdata} <= {1'b1, 8'h87, 8'h01};
    @(posedge mclk);
    sfr_we <= 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk("deferred", 8'h04, {5'h0, instr_done, idle, op_ready});
    @(negedge mclk);
    chk("idle after end", 8'h01, {7'h0, idle});
    irq();
    $display("test pipe done");
  endtask : t_pipe
  task automatic t_stop;
    sfr(1'b1, 8'h87, 8'h02);
    @(negedge mclk);
    chk("stop clocks", 8'h08, {4'h0, stop, cpu_clk_en, periph_clk_en, osc_en});
    irq();
    chk("still stop", 8'h01, {7'h0, stop});
    do_reset();
    @(negedge mclk);
    chk("after reset", 8'h00, {6'h0, stop, restart});
    sfr(1'b0, 8'h87, 8'h00);
    chk("flags cleared", 8'h00, sfr_rdata);
    $display("test stop done");
  endtask : t_stop
  // =====================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #(100 * 5000);
    err_count++;
    end_sim();
  end
  initial begin
    {rstn, op_valid, br_taken, sfr_we, sfr_rd, irq_pend} = '0;
    {opcode, sfr_addr, sfr_wdata} = '0;
    err_count = 0;
    total_checks = 0;
    do_reset();
    t_timing();
    t_regs();
    t_idle();
    t_pipe();
    t_timing();
    t_stop();
    end_sim();
  end
endmodule : tb_ctp_core_timing
`default_nettype wire
